// >>> decode_if.sv
// Carries codes from the register bank to its decoder and the results back.
// Assumes both ends run on the same clock; the results are combinational.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  import rcgc_pkg::*;
  gain_code_t gain_code;
  logic       buffer_enable;
  trim_code_t trim_code;
  gain_x100_t gain_x100;
  slope_t     slope;
  modport bank (output gain_code, output buffer_enable, output trim_code, input gain_x100, input slope);
  modport decoder (input gain_code, input buffer_enable, input trim_code, output gain_x100, output slope);
endinterface
`default_nettype wire

// >>> gain_slope_decode.sv
// Combinational decoder: buffer gain code to gain times 100, trim code to slope.
// Assumes the bank registers the results before they leave the block.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_gain_calib_regs.svh"
module gain_slope_decode
  import rcgc_pkg::*;
(
  decode_if.decoder dec
);

  ////////////////////////////////////////////////////////////////////////////
  // Gain table, hundredths; unlisted codes fall back to unity
  function automatic gain_x100_t gain_of(input gain_code_t code);
    unique case (code)
      5'h01:   gain_of = 10'h0C8;
      5'h02:   gain_of = 10'h064;
      5'h03:   gain_of = 10'h043;
      5'h04:   gain_of = 10'h032;
      5'h05:   gain_of = 10'h028;
      5'h06:   gain_of = 10'h021;
      5'h07:   gain_of = 10'h01D;
      5'h08:   gain_of = 10'h019;
      5'h09:   gain_of = 10'h016;
      5'h0A:   gain_of = 10'h014;
      5'h11:   gain_of = 10'h3E8;
      5'h12:   gain_of = 10'h1F4;
      5'h13:   gain_of = 10'h14D;
      5'h14:   gain_of = 10'h0FA;
      5'h15:   gain_of = 10'h0C8;
      5'h16:   gain_of = 10'h0A7;
      5'h17:   gain_of = 10'h08F;
      5'h18:   gain_of = 10'h07D;
      5'h19:   gain_of = 10'h06F;
      5'h1A:   gain_of = 10'h064;
      default: gain_of = `GAIN_UNITY_X100;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bypassed buffer passes the signal at unity
  always_comb begin
    dec.gain_x100 = dec.buffer_enable ? gain_of(dec.gain_code) : `GAIN_UNITY_X100;
    dec.slope     = slope_t'(`SLOPE_BASE - {3'h0, dec.trim_code});
  end

endmodule // gain_slope_decode
`default_nettype wire

// >>> host_model.sv
// Host model: drives register strobes as the SPI front end would.
// Assumes calls start 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import rcgc_pkg::*;
(
  input  wire logic      clock,
  output var  reg_addr_t reg_addr,
  output var  logic      reg_write,
  output var  logic      reg_read,
  output var  reg_data_t reg_wdata,
  input  wire reg_data_t reg_rdata
);
  // Idle bus
  initial begin
    reg_addr = 4'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 8'h00;
  end
  // One strobe, then a spare edge; idle address and data inverted, strobes low, so stale values never look valid
  task automatic xfer(input logic w, input reg_addr_t a, input reg_data_t d, output reg_data_t q);
    reg_addr = a;
    reg_wdata = d;
    reg_write = w;
    reg_read = !w;
    @(posedge clock);
    #1;
    q = reg_rdata;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clock);
    #1;
  endtask
  // Clear the power flag right after power-up
  task automatic por_clear;
    reg_data_t q;
    xfer(1'b1, 4'h7, 8'h00, q);
  endtask
endmodule // host_model
`default_nettype wire

// >>> rcgc_asserts.sv
// Checker for the reset-cause, gain and calibration register bank.
// Assumes one clock domain; bound to the bank's top ports below.
`timescale 1ns/1ps
`default_nettype none
module rcgc_asserts
  import rcgc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire reg_addr_t  reg_addr,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire reg_data_t  reg_wdata,
  input wire reg_data_t  reg_rdata,
  input wire logic       watchdog_timeout_event,
  input wire logic       watchdog_trigger_pin,
  input wire logic       buffer_select,
  input wire logic       watchdog_timeout_flag,
  input wire logic       power_on_flag,
  input wire gain_code_t adc_buffer_gain,
  input wire gain_x100_t applied_gain_x100,
  input wire trim_code_t slope_trim_code,
  input wire slope_t     slope_lsb_per_k
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Reads show the state held before the taking edge
  AST_RD_RC: assert property (reg_read && reg_addr == 4'h7 |=> reg_rdata[7:2] == 6'h00)
    else $error("reset cause high bits set");
  AST_RD_GAIN: assert property (reg_read && reg_addr == 4'hA |=> reg_rdata == {3'h0, $past(adc_buffer_gain)})
    else $error("gain readback wrong");
  AST_RD_CAL: assert property (reg_read && reg_addr == 4'hB |=> reg_rdata == {$past(slope_trim_code), 3'h0})
    else $error("trim readback wrong");
  AST_SLOPE: assert property (slope_lsb_per_k == 8'hCD - {3'h0, $past(slope_trim_code)})
    else $error("slope not minus 51 minus trim");
  AST_BYPASS: assert property (!buffer_select |=> applied_gain_x100 == 10'h064)
    else $error("bypass gain not unity");
  AST_TO_SET: assert property (watchdog_timeout_event |=> watchdog_timeout_flag)
    else $error("timeout flag not set");
  AST_TO_KEEP: assert property ($rose(watchdog_timeout_flag) |-> $past(watchdog_timeout_event))
    else $error("timeout flag set without event");
  AST_POR_NOSET: assert property (!$rose(power_on_flag))
    else $error("power flag set outside reset");
  AST_POR_CLR: assert property (reg_write && reg_addr == 4'h7 && !reg_wdata[0] |=> !power_on_flag)
    else $error("power flag not cleared by write");
  AST_GAIN_WR: assert property (reg_write && reg_addr == 4'hA |=> {3'h0, adc_buffer_gain} == ($past(reg_wdata) & 8'h1F))
    else $error("gain write lost");
  // Pin fall clears the flag four edges on, unless a timeout intervenes
  AST_TO_CLR: assert property ($fell(watchdog_trigger_pin) ##1 (!watchdog_timeout_event)[*4] |-> !watchdog_timeout_flag)
    else $error("timeout flag not cleared");
endmodule // rcgc_asserts
bind reset_cause_gain_calib_regs rcgc_asserts chk (.clock, .rst_b, .reg_addr, .reg_write, .reg_read, .reg_wdata,
  .reg_rdata, .watchdog_timeout_event, .watchdog_trigger_pin, .buffer_select, .watchdog_timeout_flag,
  .power_on_flag, .adc_buffer_gain, .applied_gain_x100, .slope_trim_code, .slope_lsb_per_k);
`default_nettype wire

// >>> rcgc_pkg.sv
// Types shared by the reset-cause, gain and calibration register bank.
// Field widths are fixed here; the constants header supplies offsets, field positions and reset values.
package rcgc_pkg;
  typedef logic [3:0]        reg_addr_t;
  typedef logic [7:0]        reg_data_t;
  typedef logic [4:0]        gain_code_t;
  typedef logic [9:0]        gain_x100_t;
  typedef logic [4:0]        trim_code_t;
  typedef logic signed [7:0] slope_t;
endpackage

// >>> reset_cause_gain_calib_regs.sv
// Reset-cause, buffer gain and slope calibration registers of the sensor.
// Assumes a front end that turns SPI frames into one-cycle register strobes,
// a watchdog that pulses on time-out, and an OTP word already stable.
`timescale 1ns/1ps
`default_nettype none
`include "reset_cause_gain_calib_regs.svh"

module reset_cause_gain_calib_regs
  import rcgc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire reg_addr_t  reg_addr,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire reg_data_t  reg_wdata,
  output var  reg_data_t  reg_rdata,
  input  wire logic       watchdog_timeout_event,
  input  wire logic       watchdog_trigger_pin,
  input  wire logic       buffer_select,
  input  wire trim_code_t otp_slope_trim,
  output var  logic       watchdog_timeout_flag,
  output var  logic       power_on_flag,
  output var  gain_code_t adc_buffer_gain,
  output var  gain_x100_t applied_gain_x100,
  output var  trim_code_t slope_trim_code,
  output var  slope_t     slope_lsb_per_k
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic       trig_s1;
  logic       trig_s2;
  logic       trig_s3;
  logic       trig_level;
  logic       next_trig_level;
  logic       trig_fall;
  logic       next_timeout;
  logic       next_por;
  gain_code_t next_gain;
  trim_code_t next_trim;
  reg_data_t  next_rdata;
  gain_x100_t next_applied;
  slope_t     next_slope;
  logic       wr_rc;
  logic       wr_gain;

  decode_if dec ();

  gain_slope_decode u_decode (
    .dec (dec.decoder)
  );

  assign dec.gain_code     = adc_buffer_gain;
  assign dec.buffer_enable = buffer_select;
  assign dec.trim_code     = slope_trim_code;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser; a level change counts once stages 2 and 3 agree
  // Stage 1 feeds only stage 2, so a metastable value never reaches the filter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trig_s1    <= `SYNC_IDLE;
      trig_s2    <= `SYNC_IDLE;
      trig_s3    <= `SYNC_IDLE;
      trig_level <= `SYNC_IDLE;
    end else begin
      trig_s1    <= watchdog_trigger_pin;
      trig_s2    <= trig_s1;
      trig_s3    <= trig_s2;
      trig_level <= next_trig_level;
    end
  end

  // Filtered level and its falling edge
  // A low pulse shorter than one clock is filtered out and clears nothing
  always_comb begin
    next_trig_level = (trig_s2 == trig_s3) ? trig_s3 : trig_level;
    trig_fall       = trig_level && (trig_s2 == trig_s3) && !trig_s3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes, one per writable register
  // Read-only and unmapped offsets get none, so writes there vanish
  always_comb begin
    wr_rc   = reg_write && (reg_addr == `RC_OFFSET);
    wr_gain = reg_write && (reg_addr == `GAIN_OFFSET);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time-out flag: set by the watchdog, cleared by a trigger pin falling edge
  // A time-out pulse in the same cycle as a falling edge wins the flag, so a
  // reset cause is never lost to a coincident service of the watchdog
  always_comb begin
    if (watchdog_timeout_event) begin
      next_timeout = 1'b1;
    end else if (trig_fall) begin
      next_timeout = 1'b0;
    end else begin
      next_timeout = watchdog_timeout_flag;
    end
  end

  // Besides a pin fall, only power-on clears it; a watchdog master reset must not reach rst_b
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_timeout_flag <= `RC_TO_RESET;
    end else begin
      watchdog_timeout_flag <= next_timeout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on flag: writing 1 leaves it alone; only power-on sets it
  // Host clears it early, so a later power-on shows up as a return to 1
  // No set and clear can meet: the set is the asynchronous reset itself
  always_comb begin
    if (wr_rc && !reg_wdata[`RC_POR_BIT]) begin
      next_por = 1'b0;
    end else begin
      next_por = power_on_flag;
    end
  end

  // Power-on flag register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_on_flag <= `RC_POR_RESET;
    end else begin
      power_on_flag <= next_por;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer gain code; upper write bits are dropped, they do not exist
  // Any five-bit code is kept, an undefined one decodes to unity
  always_comb begin
    next_gain = wr_gain ? reg_wdata[`GAIN_MSB:`GAIN_LSB] : adc_buffer_gain;
  end

  // Gain code register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      adc_buffer_gain <= `GAIN_RESET;
    end else begin
      adc_buffer_gain <= next_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // OTP trim copy and decoded results; registered so every output leaves a
  // flop, at the cost of one cycle of lag behind a new code
  always_comb begin
    next_trim    = otp_slope_trim;
    next_applied = dec.gain_x100;
    next_slope   = dec.slope;
  end

  // Trim has no defined reset value; zero keeps the slope at its base meanwhile
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slope_trim_code   <= `CALIB_TRIM_RESET;
      applied_gain_x100 <= `GAIN_UNITY_X100;
      slope_lsb_per_k   <= slope_t'(`SLOPE_BASE);
    end else begin
      slope_trim_code   <= next_trim;
      applied_gain_x100 <= next_applied;
      slope_lsb_per_k   <= next_slope;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unimplemented bits and unmapped offsets read as zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_read) begin
      next_rdata = `READ_ZERO;
      unique case (reg_addr)
        `RC_OFFSET: begin
          next_rdata[`RC_POR_BIT] = power_on_flag;
          next_rdata[`RC_TO_BIT]  = watchdog_timeout_flag;
        end
        `GAIN_OFFSET: begin
          next_rdata[`GAIN_MSB:`GAIN_LSB] = adc_buffer_gain;
        end
        `CALIB_OFFSET: begin
          next_rdata[`CALIB_TRIM_MSB:`CALIB_TRIM_LSB] = slope_trim_code;
        end
        default: begin
          next_rdata = `READ_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register; holds the last read until the next one
  // rst_b is the power-on reset, watchdog reset must not reach here
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `READ_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // reset_cause_gain_calib_regs
`default_nettype wire

// >>> reset_cause_gain_calib_regs.svh
// Register offsets, field positions and reset values of the reset-cause,
// buffer gain and slope calibration bank. Included by the bank's RTL files.
`ifndef RESET_CAUSE_GAIN_CALIB_REGS_SVH
`define RESET_CAUSE_GAIN_CALIB_REGS_SVH

`define RC_OFFSET          4'h7
`define GAIN_OFFSET        4'hA
`define CALIB_OFFSET       4'hB

`define RC_POR_BIT         0
`define RC_TO_BIT          1
`define RC_POR_RESET       1'b1
`define RC_TO_RESET        1'b0

`define GAIN_MSB           4
`define GAIN_LSB           0
`define GAIN_RESET         5'h1A

`define CALIB_TRIM_MSB     7
`define CALIB_TRIM_LSB     3
`define CALIB_TRIM_RESET   5'h00

`define SLOPE_BASE         8'hCD
`define GAIN_UNITY_X100    10'h064
`define READ_ZERO          8'h00
`define SYNC_IDLE          1'b1

`endif

// >>> test_reset_cause_gain_calib_regs.sv
// Testbench for the reset-cause, gain and calibration bank.
// Assumes host_model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_gain_calib_regs;
  import rcgc_pkg::*;
  logic       clock = 1'b0;
  logic       rst_b, reg_write, reg_read, watchdog_timeout_event, watchdog_trigger_pin, buffer_select;
  logic       watchdog_timeout_flag, power_on_flag;
  reg_addr_t  reg_addr;
  reg_data_t  reg_wdata, reg_rdata;
  trim_code_t otp_slope_trim, slope_trim_code;
  gain_code_t adc_buffer_gain;
  gain_x100_t applied_gain_x100;
  slope_t     slope_lsb_per_k;
  int         failures = 0;
  int         n_checks = 0;
  int         cycles = 0;
  logic [9:0] gx [20] = '{200, 100, 67, 50, 40, 33, 29, 25, 22, 20, 1000, 500, 333, 250, 200, 167, 143, 125, 111, 100};
  reset_cause_gain_calib_regs dut (.clock, .rst_b, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .watchdog_timeout_event, .watchdog_trigger_pin, .buffer_select, .otp_slope_trim, .watchdog_timeout_flag,
    .power_on_flag, .adc_buffer_gain, .applied_gain_x100, .slope_trim_code, .slope_lsb_per_k);
  host_model host (.clock, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata);
  always #50 clock = ~clock;
  ////////////////////////////////////////
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      results();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    reg_data_t q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input reg_addr_t a, input logic [9:0] e);
    reg_data_t q;
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    watchdog_timeout_event = 1'b0;
    watchdog_trigger_pin = 1'b1;
    buffer_select = 1'b1;
    otp_slope_trim = 5'h13;
    tick(8);
    rst_b = 1'b1;
    tick(1);
    rd(4'h7, 10'h001);
    chk(power_on_flag, 10'h001);
    rd(4'hA, 10'h01A);
    rd(4'hB, 10'h098);
    chk({2'h0, slope_lsb_per_k}, 10'h0BA);
    $display("reset values done");
    wr(4'h7, 8'hFF);
    rd(4'h7, 10'h001);
    host.por_clear();
    chk(power_on_flag, 10'h000);
    rd(4'h7, 10'h000);
    wr(4'hA, 8'hFF);
    chk(adc_buffer_gain, 10'h01F);
    rd(4'hA, 10'h01F);
    wr(4'hB, 8'h00);
    rd(4'hB, 10'h098);
    rd(4'h3, 10'h000);
    $display("access kinds done");
    // Every defined gain code, both halves of the table
    for (int i = 0; i < 20; i++) begin
      wr(4'hA, 8'(i < 10 ? i + 1 : i + 7));
      chk(applied_gain_x100, gx[i]);
    end
    wr(4'hA, 8'h11);
    buffer_select = 1'b0;
    tick(2);
    chk(applied_gain_x100, 10'd100);
    buffer_select = 1'b1;
    tick(2);
    chk(applied_gain_x100, 10'd1000);
    wr(4'hA, 8'h0B);
    chk(applied_gain_x100, 10'd100);
    $display("gain decode done");
    watchdog_timeout_event = 1'b1;
    tick(1);
    watchdog_timeout_event = 1'b0;
    wr(4'h7, 8'h00);
    rd(4'h7, 10'h002);
    watchdog_trigger_pin = 1'b0;
    tick(3);
    chk(watchdog_timeout_flag, 10'h001);
    tick(1);
    chk(watchdog_timeout_flag, 10'h000);
    watchdog_trigger_pin = 1'b1;
    otp_slope_trim = 5'h1F;
    tick(2);
    chk({2'h0, slope_lsb_per_k}, 10'h0AE);
    chk(slope_trim_code, 10'h01F);
    rd(4'hB, 10'h0F8);
    // Time-out pulse in the cycle the pin fall clears: the set must win
    watchdog_timeout_event = 1'b1;
    tick(1);
    watchdog_timeout_event = 1'b0;
    watchdog_trigger_pin = 1'b0;
    tick(3);
    watchdog_timeout_event = 1'b1;
    tick(1);
    watchdog_timeout_event = 1'b0;
    chk(watchdog_timeout_flag, 10'h001);
    watchdog_trigger_pin = 1'b1;
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    tick(1);
    rd(4'h7, 10'h001);
    $display("reset cause done");
    results();
  end
endmodule // test_reset_cause_gain_calib_regs
`default_nettype wire
